// ---- inc/codec_ctrl_map.svh ----
// Register offsets, field positions, reset values and fixed figures of the codec control bank.
// Assumes a 32-bit AXI4-Lite register bus with five address bits.
`ifndef CODEC_CTRL_MAP_SVH
`define CODEC_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DIVIDER_REG_OFS    5'h00
`define ADC_GAIN_REG_OFS   5'h04
`define DAC_GAIN_REG_OFS   5'h08
`define DIV_STATUS_OFS     5'h0C
`define GAIN_STATUS_OFS    5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SEL_BIT            7
`define N_MSB              6
`define N_LSB              3
`define P_MSB              2
`define P_LSB              0
`define TARGET_MSB         7
`define TARGET_LSB         6
`define STAT_N_LSB         8
`define STAT_P_LSB         16
`define STAT_ADC_MUTE_BIT  8
`define STAT_DAC_LSB       16
`define STAT_DAC_MUTE_BIT  24

// ----------------------------------------------------------------------------
// Reset values and decode figures
// ----------------------------------------------------------------------------
`define M_RAW_RST          7'h00
`define N_RAW_RST          4'h0
`define P_RAW_RST          3'h0
`define DIVIDER_LAST_RST   8'h00
`define GAIN_FIELD_RST     6'h00
`define M_ZERO_VALUE       8'h80
`define N_ZERO_VALUE       5'h10
`define P_ZERO_VALUE       4'h8
`define FS_SCALE           19'h00010
`define GAIN_STEP          7'h03
`define GAIN_LINEAR_TOP    6'h1C
`define GAIN_CODE_48DB     6'h1D
`define GAIN_CODE_54DB     6'h1E
`define GAIN_CODE_MUTE     6'h1F
`define GAIN_48DB_HALF     7'h60
`define GAIN_54DB_HALF     7'h6C

`endif

// ---- inc/codec_ctrl_pkg.sv ----
// Types shared by the codec control bank modules.
// Assumes the map header supplies all numeric figures.
package codec_ctrl_pkg;

  typedef enum logic [1:0] {
    GAIN_TO_ADC = 2'b00,
    GAIN_TO_DAC = 2'b01
  } gain_target_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage

// ---- core/pga_gain_decode.sv ----
// Registered decoder from a six-bit amplifier code to gain magnitude in half-dB units.
// Assumes the code is held stable in a register of the caller.
`timescale 1ns/1ns
`include "codec_ctrl_map.svh"

module pga_gain_decode (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Code in
  input  wire logic [5:0] code,
  // Decoded gain out
  output logic      [6:0] mag_half_db,
  output logic            mute
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  // Codes with the top bit set have no defined gain and are treated as mute.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mag_half_db <= 7'h00;
      mute        <= 1'b0;
    end else begin
      mute        <= 1'b0;
      mag_half_db <= 7'h00;
      if (code <= `GAIN_LINEAR_TOP) begin
        mag_half_db <= 7'(code) * `GAIN_STEP; // RQ5 RQ8
      end else begin
        case (code)
          `GAIN_CODE_48DB: mag_half_db <= `GAIN_48DB_HALF; // RQ6 RQ8
          `GAIN_CODE_54DB: mag_half_db <= `GAIN_54DB_HALF; // RQ6 RQ8
          default:         mute        <= 1'b1; // RQ7 RQ8
        endcase
      end
    end
  end

endmodule // pga_gain_decode

// ---- core/fs_rate_gen.sv ----
// Frame sync rate generator: one-cycle pulse every sixteen times M times N times P clocks.
// Assumes the divider values are decoded and held by the caller.
`timescale 1ns/1ns
`include "codec_ctrl_map.svh"

module fs_rate_gen (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Divider values
  input  wire logic [7:0] m_value,
  input  wire logic [4:0] n_value,
  input  wire logic [3:0] p_value,
  // Frame sync
  output logic            frame_sync_pulse
);

  logic [18:0] divisor;
  logic [18:0] cnt_reg;

  assign divisor = 19'(m_value) * 19'(n_value) * 19'(p_value) * `FS_SCALE; // RQ1

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // A divider shrunk below the current count reloads at once rather than wrapping.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg          <= 19'h00000;
      frame_sync_pulse <= 1'b0;
    end else if (cnt_reg >= divisor - 19'h00001) begin
      cnt_reg          <= 19'h00000;
      frame_sync_pulse <= 1'b1; // RQ1
    end else begin
      cnt_reg          <= cnt_reg + 19'h00001;
      frame_sync_pulse <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [18:0] gap_reg;
  logic        seen_reg;
  logic        moved_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg   <= 19'h00000;
      seen_reg  <= 1'b0;
      moved_reg <= 1'b0;
    end else if (frame_sync_pulse) begin
      gap_reg   <= 19'h00001;
      seen_reg  <= 1'b1;
      moved_reg <= 1'b0;
    end else begin
      gap_reg   <= gap_reg + 19'h00001;
      moved_reg <= moved_reg | (divisor != $past(divisor));
    end
  end

  a_fs_period: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
    (frame_sync_pulse && seen_reg && !moved_reg && $stable(divisor)) |-> gap_reg == divisor)
    else $error("frame sync spacing differs from sixteen times M N P");

  c_fs_pulse: cover property (@(posedge aclk) disable iff (!aresetn)
    frame_sync_pulse && seen_reg);

endmodule // fs_rate_gen

// ---- core/codec_ctrl_regs.sv ----
// Codec control bank: frame sync divider and amplifier gain registers on AXI4-Lite.
// Assumes one clock aclk at 100 MHz as master clock and a synchronous active-low reset.
//
// Notes on behaviour
// RQ1: Frame sync rate is master clock over sixteen times M times N times P.
// RQ2: Select bit set: M from low seven bits, zero means 128.
// RQ3: Select bit clear: N from bits six to three, zero means 16.
// RQ4: Select bit clear: P from bits two to zero, zero means 8.
// RQ5: ADC codes 0 to 28 give 0 to 42 dB in 1.5 dB steps.
// RQ6: ADC code 29 gives 48 dB, code 30 gives 54 dB.
// RQ7: ADC code 31 mutes the ADC input amplifier.
// RQ8: DAC code 31 mutes; codes 30 and 29 attenuate by 54 and 48 dB.
// RQ9: Software clears the select bit for N and P, sets it for M.
// RQ10: Gain write with top bits 00 goes to ADC, 01 to DAC.
// RQ11: M, N and P are stored apart; writing one keeps the others. A write with the select bit clear sets N and P together.
`timescale 1ns/1ns
`include "codec_ctrl_map.svh"

module codec_ctrl_regs #(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Codec controls
  output logic                   frame_sync_pulse,
  output logic [6:0]             adc_gain_half_db,
  output logic                   adc_mute,
  output logic [6:0]             dac_atten_half_db,
  output logic                   dac_mute
);

  // --------------------------------------------------------------------------
  // Write channel holding
  // --------------------------------------------------------------------------
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] awaddr_hold;
  logic [7:0]        wdata_hold;
  logic              wstrb0_hold;
  logic              wr_en;
  logic [4:0]        wr_word;
  logic              wr_map_ok;

  assign awready   = !aw_full_reg;
  assign wready    = !w_full_reg;
  assign wr_en     = aw_full_reg && w_full_reg && !bvalid;
  assign wr_word   = {awaddr_hold[4:2], 2'b00};
  assign wr_map_ok = (wr_word == `DIVIDER_REG_OFS) || (wr_word == `ADC_GAIN_REG_OFS)
                     || (wr_word == `DAC_GAIN_REG_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      awaddr_hold <= '0;
    end else if (awvalid && awready) begin
      aw_full_reg <= 1'b1;
      awaddr_hold <= awaddr;
    end else if (wr_en) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg  <= 1'b0;
      wdata_hold  <= 8'h00;
      wstrb0_hold <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_reg  <= 1'b1;
      wdata_hold  <= wdata[7:0];
      wstrb0_hold <= wstrb[0];
    end else if (wr_en) begin
      w_full_reg  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= codec_ctrl_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_map_ok ? codec_ctrl_pkg::RESP_OKAY : codec_ctrl_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Divider storage
  // --------------------------------------------------------------------------
  logic [6:0] m_raw_reg;
  logic [3:0] n_raw_reg;
  logic [2:0] p_raw_reg;
  logic [7:0] divider_last_reg;
  logic       divider_wr;
  logic [7:0] m_value;
  logic [4:0] n_value;
  logic [3:0] p_value;

  assign divider_wr = wr_en && wstrb0_hold && (wr_word == `DIVIDER_REG_OFS);

  // Each value has its own store so a write of M never disturbs N and P.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_raw_reg <= `M_RAW_RST;
    end else if (divider_wr && wdata_hold[`SEL_BIT]) begin
      m_raw_reg <= wdata_hold[6:0]; // RQ2 RQ11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_raw_reg <= `N_RAW_RST;
      p_raw_reg <= `P_RAW_RST;
    end else if (divider_wr && !wdata_hold[`SEL_BIT]) begin
      n_raw_reg <= wdata_hold[`N_MSB:`N_LSB]; // RQ3 RQ11
      p_raw_reg <= wdata_hold[`P_MSB:`P_LSB]; // RQ4 RQ11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divider_last_reg <= `DIVIDER_LAST_RST;
    end else if (divider_wr) begin
      divider_last_reg <= wdata_hold;
    end
  end

  assign m_value = (m_raw_reg == 7'h00) ? `M_ZERO_VALUE : {1'b0, m_raw_reg}; // RQ2
  assign n_value = (n_raw_reg == 4'h0) ? `N_ZERO_VALUE : {1'b0, n_raw_reg}; // RQ3
  assign p_value = (p_raw_reg == 3'h0) ? `P_ZERO_VALUE : {1'b0, p_raw_reg}; // RQ4

  // --------------------------------------------------------------------------
  // Gain storage
  // --------------------------------------------------------------------------
  logic       gain_wr;
  logic [1:0] gain_target;
  logic [5:0] adc_field_reg;
  logic [5:0] dac_field_reg;

  assign gain_wr     = wr_en && wstrb0_hold && ((wr_word == `ADC_GAIN_REG_OFS)
                       || (wr_word == `DAC_GAIN_REG_OFS));
  assign gain_target = wdata_hold[`TARGET_MSB:`TARGET_LSB];

  // The top two data bits pick the amplifier; codes 1x are dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_field_reg <= `GAIN_FIELD_RST;
    end else if (gain_wr && gain_target == codec_ctrl_pkg::GAIN_TO_ADC) begin
      adc_field_reg <= wdata_hold[5:0]; // RQ10
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_field_reg <= `GAIN_FIELD_RST;
    end else if (gain_wr && gain_target == codec_ctrl_pkg::GAIN_TO_DAC) begin
      dac_field_reg <= wdata_hold[5:0]; // RQ10
    end
  end

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  fs_rate_gen u_fs_rate_gen (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .m_value          (m_value),
    .n_value          (n_value),
    .p_value          (p_value),
    .frame_sync_pulse (frame_sync_pulse)
  );

  pga_gain_decode u_adc_gain (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .code        (adc_field_reg),
    .mag_half_db (adc_gain_half_db),
    .mute        (adc_mute)
  );

  pga_gain_decode u_dac_gain (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .code        (dac_field_reg),
    .mag_half_db (dac_atten_half_db),
    .mute        (dac_mute)
  );

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  logic [4:0] rd_word;

  assign arready = !rvalid;
  assign rd_word = {araddr[4:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= codec_ctrl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= codec_ctrl_pkg::RESP_OKAY;
      rdata  <= 32'h00000000;
      case (rd_word)
        `DIVIDER_REG_OFS:  rdata[7:0] <= divider_last_reg;
        `ADC_GAIN_REG_OFS: rdata[7:0] <= {codec_ctrl_pkg::GAIN_TO_ADC, adc_field_reg};
        `DAC_GAIN_REG_OFS: rdata[7:0] <= {codec_ctrl_pkg::GAIN_TO_DAC, dac_field_reg};
        `DIV_STATUS_OFS: begin
          rdata[7:0]                    <= m_value;
          rdata[`STAT_N_LSB+:5]         <= n_value;
          rdata[`STAT_P_LSB+:4]         <= p_value;
        end
        `GAIN_STATUS_OFS: begin
          rdata[6:0]                    <= adc_gain_half_db;
          rdata[`STAT_ADC_MUTE_BIT]     <= adc_mute;
          rdata[`STAT_DAC_LSB+:7]       <= dac_atten_half_db;
          rdata[`STAT_DAC_MUTE_BIT]     <= dac_mute;
        end
        default: rresp <= codec_ctrl_pkg::RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_m_decode: assert property ((divider_wr && wdata_hold[`SEL_BIT]) |=> // RQ2
    m_value == (($past(wdata_hold[6:0]) == 7'h00) ? 8'h80 : {1'b0, $past(wdata_hold[6:0])}))
    else $error("M value not decoded from the low seven bits");

  a_n_decode: assert property ((divider_wr && !wdata_hold[`SEL_BIT]) |=> // RQ3
    n_value == (($past(wdata_hold[6:3]) == 4'h0) ? 5'h10 : {1'b0, $past(wdata_hold[6:3])}))
    else $error("N value not decoded from bits six to three");

  a_p_decode: assert property ((divider_wr && !wdata_hold[`SEL_BIT]) |=> // RQ4
    p_value == (($past(wdata_hold[2:0]) == 3'h0) ? 4'h8 : {1'b0, $past(wdata_hold[2:0])}))
    else $error("P value not decoded from bits two to zero");

  a_div_separate: assert property ((divider_wr && wdata_hold[`SEL_BIT]) |=> // RQ11
    $stable(n_raw_reg) && $stable(p_raw_reg))
    else $error("writing M disturbed N or P");

  a_adc_linear: assert property ((gain_wr && gain_target == 2'b00 // RQ5
    && wdata_hold[5:0] <= 6'h1C) |-> ##2
    (adc_gain_half_db == 7'($past(wdata_hold[5:0], 2)) * 7'h03) && !adc_mute)
    else $error("ADC gain not in 1.5 dB steps");

  a_adc_high: assert property ((gain_wr && gain_target == 2'b00 // RQ6
    && (wdata_hold[5:0] == 6'h1D || wdata_hold[5:0] == 6'h1E)) |-> ##2
    adc_gain_half_db == (($past(wdata_hold[0], 2)) ? 7'h60 : 7'h6C))
    else $error("ADC top gain codes decoded wrongly");

  a_adc_mute: assert property ((gain_wr && gain_target == 2'b00 // RQ7
    && wdata_hold[5:0] == 6'h1F) |-> ##2 adc_mute ##1 adc_mute)
    else $error("ADC mute code did not mute");

  a_dac_codes: assert property ((gain_wr && gain_target == 2'b01 // RQ8
    && wdata_hold[5:1] == 5'h0F) |-> ##2 dac_mute == $past(wdata_hold[0], 2)
    && (dac_mute || dac_atten_half_db == 7'h6C))
    else $error("DAC mute or 54 dB attenuation code decoded wrongly");

  a_gain_route: assert property ((gain_wr && gain_target == 2'b01) |=> // RQ10
    $stable(adc_field_reg) && dac_field_reg == $past(wdata_hold[5:0]))
    else $error("DAC gain write reached the ADC field");

  a_bresp_order: assert property ((awvalid && awready && wvalid && wready) |=>
    wr_en ##1 bvalid)
    else $error("write response not raised one cycle after the write");

  c_write_m: cover property (divider_wr && wdata_hold[`SEL_BIT]);
  c_write_np: cover property (divider_wr && !wdata_hold[`SEL_BIT]);
  c_dac_mute: cover property (gain_wr && gain_target == 2'b01 && wdata_hold[5:0] == 6'h1F);
  c_read: cover property (rvalid && rready);

endmodule // codec_ctrl_regs

// ---- test/tb_codec_ctrl_regs.sv ----
// Self-checking bench for the codec control bank, driven over AXI4-Lite.
// Assumes the map header for offsets and the default five-bit address bus.
`timescale 1ns/1ns
`include "codec_ctrl_map.svh"

module tb_codec_ctrl_regs;
  logic        aclk, aresetn;
  logic [4:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        frame_sync_pulse, adc_mute, dac_mute;
  logic [6:0]  adc_gain_half_db, dac_atten_half_db;
  int          n_errors, checked, cycles;

  codec_ctrl_regs i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .frame_sync_pulse(frame_sync_pulse), .adc_gain_half_db(adc_gain_half_db),
    .adc_mute(adc_mute), .dac_atten_half_db(dac_atten_half_db), .dac_mute(dac_mute));

  // ---------------------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Bus tasks: ready is sampled mid-cycle, so the following edge is the handshake
  // ---------------------------------------------------------------------------
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!((ta || !awvalid) && (tw || !wvalid)));
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, {24'h000000, d}, r);
    chk({30'h0, r}, 32'h0000_0000);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  function automatic logic [31:0] div_stat(input logic [7:0] m, input logic [4:0] n,
                                           input logic [3:0] p);
    return {12'h000, p, 3'h0, n, m};
  endfunction

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset();
    rd_chk(`DIVIDER_REG_OFS, 32'h0000_0000, 2'b00);
    rd_chk(`DIV_STATUS_OFS, div_stat(8'h80, 5'h10, 4'h8), 2'b00);
    rd_chk(`GAIN_STATUS_OFS, 32'h0000_0000, 2'b00);
    $display("test_reset done");
  endtask

  task automatic test_dividers();
    wr_ok(`DIVIDER_REG_OFS, 8'h81);
    wr_ok(`DIVIDER_REG_OFS, 8'h7F);
    rd_chk(`DIV_STATUS_OFS, div_stat(8'h01, 5'h0F, 4'h7), 2'b00);
    wr_ok(`DIVIDER_REG_OFS, 8'hFF);
    rd_chk(`DIV_STATUS_OFS, div_stat(8'h7F, 5'h0F, 4'h7), 2'b00);
    wr_ok(`DIVIDER_REG_OFS, 8'h00);
    rd_chk(`DIV_STATUS_OFS, div_stat(8'h7F, 5'h10, 4'h8), 2'b00);
    wr_ok(`DIVIDER_REG_OFS, 8'h80);
    rd_chk(`DIV_STATUS_OFS, div_stat(8'h80, 5'h10, 4'h8), 2'b00);
    rd_chk(`DIVIDER_REG_OFS, 32'h0000_0080, 2'b00);
    $display("test_dividers done");
  endtask

  task automatic fs_period(input logic [7:0] mw, input logic [7:0] npw, input int exp);
    int n;
    wr_ok(`DIVIDER_REG_OFS, mw);
    wr_ok(`DIVIDER_REG_OFS, npw);
    n = 0;
    do begin
      @(negedge aclk);
      n = n + 1;
    end while (frame_sync_pulse !== 1'b1 && n < 2000);
    n = 0;
    do begin
      @(negedge aclk);
      n = n + 1;
    end while (frame_sync_pulse !== 1'b1 && n < 2000);
    chk(n, exp);
  endtask

  task automatic test_frame_sync();
    fs_period(8'h81, 8'h09, 16);
    fs_period(8'h83, 8'h0A, 96);
    fs_period(8'h81, 8'h08, 128);
    $display("test_frame_sync done");
  endtask

  function automatic logic [6:0] gain_half(input logic [5:0] c);
    if (c <= 6'h1C) return 7'(c) * 7'h03;
    if (c == 6'h1D) return 7'h60;
    if (c == 6'h1E) return 7'h6C;
    return 7'h00;
  endfunction

  task automatic test_gain(input logic dac);
    logic [5:0] c;
    for (int i = 0; i < 32; i++) begin
      c = 6'(i);
      wr_ok(dac ? `DAC_GAIN_REG_OFS : `ADC_GAIN_REG_OFS, {1'b0, dac, c});
      repeat (2) @(negedge aclk);
      if (dac) begin
        chk({25'h0, dac_atten_half_db}, {25'h0, gain_half(c)});
        chk({31'h0, dac_mute}, {31'h0, c == 6'h1F});
      end else begin
        chk({25'h0, adc_gain_half_db}, {25'h0, gain_half(c)});
        chk({31'h0, adc_mute}, {31'h0, c == 6'h1F});
      end
    end
    $display("test_gain done for side %0d", dac);
  endtask

  task automatic test_routing();
    wr_ok(`ADC_GAIN_REG_OFS, 8'h0A);
    wr_ok(`DAC_GAIN_REG_OFS, 8'h5D);
    rd_chk(`ADC_GAIN_REG_OFS, 32'h0000_000A, 2'b00);
    rd_chk(`DAC_GAIN_REG_OFS, 32'h0000_005D, 2'b00);
    rd_chk(`GAIN_STATUS_OFS, 32'h0060_001E, 2'b00);
    wr_ok(`DAC_GAIN_REG_OFS, 8'h1F);
    wr_ok(`ADC_GAIN_REG_OFS, 8'h5E);
    rd_chk(`GAIN_STATUS_OFS, 32'h006C_0100, 2'b00);
    wr_ok(`ADC_GAIN_REG_OFS, 8'h85);
    rd_chk(`ADC_GAIN_REG_OFS, 32'h0000_001F, 2'b00);
    rd_chk(`DAC_GAIN_REG_OFS, 32'h0000_005E, 2'b00);
    $display("test_routing done");
  endtask

  task automatic test_bad_access();
    logic [1:0] r;
    axi_write(5'h14, 32'h0000_0085, r);
    chk({30'h0, r}, 32'h0000_0002);
    axi_write(`DIV_STATUS_OFS, 32'h0000_0085, r);
    chk({30'h0, r}, 32'h0000_0002);
    @(posedge aclk);
    wstrb <= 4'hE;
    axi_write(`DIVIDER_REG_OFS, 32'h0000_0085, r);
    wstrb <= 4'hF;
    chk({30'h0, r}, 32'h0000_0000);
    rd_chk(5'h14, 32'h0000_0000, 2'b10);
    rd_chk(`DIV_STATUS_OFS, div_stat(8'h01, 5'h01, 4'h8), 2'b00);
    rd_chk(`DIVIDER_REG_OFS, 32'h0000_0008, 2'b00);
    $display("test_bad_access done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    n_errors = 0;
    checked = 0;
    cycles = 0;
    aresetn = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_dividers();
    test_frame_sync();
    test_gain(1'b0);
    test_gain(1'b1);
    test_routing();
    test_bad_access();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    final_report();
  end
endmodule // tb_codec_ctrl_regs
